// *** shared/dir_dma_pkg.sv ***
package dir_dma_pkg;
    // host i/o offsets within the adapter's eight-byte window
    localparam logic [2:0] OFFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFFS_DIR_DMA = 3'h7;

    // modem control register fields, snooped from host writes
    localparam int MCR_TERM_READY_BIT = 0;
    localparam int MCR_REQ_SEND_BIT = 1;

    // direction / dma register fields, write side
    localparam int DIR_DRIVE_BIT = 0;
    localparam int RX_INHIBIT_BIT = 1;
    localparam int DONE_CLEAR_BIT = 2;
    // read side
    localparam int RD_DIR_DRIVE_BIT = 0;
    localparam int RD_DONE_FLAG_BIT = 1;

    // reset values
    localparam logic DIR_DRIVE_RST = 1'b0;
    localparam logic RX_INHIBIT_RST = 1'b0;
    localparam logic TERM_READY_RST = 1'b0;
    localparam logic REQ_SEND_RST = 1'b0;
    localparam logic DONE_FLAG_RST = 1'b0;
    localparam logic [7:0] RD_DATA_RST = 8'h00;

    // strap synchroniser reset: line idles at mark (bit 3), straps at zero
    localparam logic [3:0] STRAP_SYNC_RST = 4'h8;

    // receiver control source
    typedef enum logic {
        RX_SRC_INHIBIT_BIT = 1'b0,
        RX_SRC_RECIPROCAL = 1'b1
    } rx_src_t;

    // transmitter release source
    typedef enum logic [1:0] {
        TX_SRC_TERM_READY = 2'b00,
        TX_SRC_REQ_SEND = 2'b01,
        TX_SRC_DIR_DRIVE = 2'b10,
        TX_SRC_ALWAYS = 2'b11
    } tx_src_t;
endpackage

// *** design/pin_sync.sv ***
module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // three-flop chain; stage1 feeds stage2 only
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= pins_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a bit changes only once the later two stages agree, which drops one-cycle glitches
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    pins_out[i] <= RESET_VAL[i];
                end else if (stage2[i] == stage3[i]) begin
                    pins_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule

// *** design/half_duplex_dir_dma_status.sv ***
// Contract
// R1 - receiver control selectable: inhibit bit or reciprocal
// R2 - inhibit option: receive-inhibit bit D1 offset 7
// R3 - inhibit 0 passes line data, 1 blocks
// R4 - receive-inhibit resets to 0, receive mode
// R5 - reciprocal: receiver enabled exactly when sender blocked
// R6 - reciprocal source follows selected sender release source
// R7 - host keeps D2-D7 when rewriting offset 4
// R8 - offset 7 read returns transfer-done in D1
// R9 - done reads 1 when finished, 0 during
// R10 - write 1 to D2 clears latch; 0 keeps
// R11 - host keeps D0-D1 when clearing latch
// R12 - three dma pacing signals, channel 0, 1, 3
// R13 - direction-drive bit D0: releases sender, reads back
// R14 - terminal-ready and request-to-send release when 1
// R15 - terminal count sets done until cleared
module half_duplex_dir_dma_status
    import dir_dma_pkg::*;
#(
    parameter int DMA_CHANNEL = 0
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [2:0] io_addr_in,
    input wire logic [7:0] io_wr_data_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    output logic [7:0] io_rd_data_out,
    output logic io_rd_valid_out,
    input wire logic uart_rx_ready_in,
    input wire logic [3:0] dma_ack_n_in,
    input wire logic dma_tc_in,
    output logic [3:0] dma_req_out,
    output logic done_irq_out,
    input wire logic receiver_ctrl_select_in,
    input wire logic [1:0] sender_ctrl_select_in,
    input wire logic rx_line_in,
    output logic uart_rxd_out,
    output logic rx_enable_out,
    output logic tx_enable_out
);
    // only channels 0, 1 and 3 are wired to the card edge
    generate
        if (!(DMA_CHANNEL == 0 || DMA_CHANNEL == 1 || DMA_CHANNEL == 3)) begin : g_bad_channel
            $error("DMA_CHANNEL must be 0, 1 or 3");
        end
    endgenerate

    localparam logic [3:0] CH_MASK = 4'(1 << DMA_CHANNEL);

    logic dir_drive;
    logic rx_inhibit;
    logic term_ready;
    logic req_send;
    logic transfer_done_flag;
    logic [3:0] strap_sync;
    logic rx_line_sync;
    rx_src_t receiver_ctrl_select;
    tx_src_t sender_ctrl_select;
    logic dma_ack_sel;
    logic wr_dir_dma;
    logic wr_modem;
    logic done_set;
    logic done_clear;
    logic next_tx_en;
    logic next_rx_en;

    // straps and line data come from outside the clock domain
    pin_sync #(
        .WIDTH(4),
        .RESET_VAL(STRAP_SYNC_RST)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .pins_in({rx_line_in, sender_ctrl_select_in, receiver_ctrl_select_in}),
        .pins_out(strap_sync)
    );

    assign receiver_ctrl_select = rx_src_t'(strap_sync[0]);
    assign sender_ctrl_select = tx_src_t'(strap_sync[2:1]);
    assign rx_line_sync = strap_sync[3];

    // host strobes are on the bus clock, so used directly
    assign wr_dir_dma = io_wr_in && (io_addr_in == OFFS_DIR_DMA);
    assign wr_modem = io_wr_in && (io_addr_in == OFFS_MODEM_CTRL);
    assign dma_ack_sel = !dma_ack_n_in[DMA_CHANNEL];
    assign done_set = dma_tc_in && dma_ack_sel;
    assign done_clear = wr_dir_dma && io_wr_data_in[DONE_CLEAR_BIT];

    // direction-drive and receive-inhibit bits; written together, host keeps the other bits
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_drive <= DIR_DRIVE_RST; // [R13]
            rx_inhibit <= RX_INHIBIT_RST; // [R4]
        end else if (wr_dir_dma) begin
            dir_drive <= io_wr_data_in[DIR_DRIVE_BIT]; // [R13]
            rx_inhibit <= io_wr_data_in[RX_INHIBIT_BIT]; // [R2] [R11]
        end
    end

    // shadow of the modem release bits; the uart keeps the full register, we only snoop
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            term_ready <= TERM_READY_RST; // [R14]
            req_send <= REQ_SEND_RST; // [R14]
        end else if (wr_modem) begin
            term_ready <= io_wr_data_in[MCR_TERM_READY_BIT]; // [R14]
            req_send <= io_wr_data_in[MCR_REQ_SEND_BIT]; // [R14] [R7]
        end
    end

    // done latch: terminal count sets it, the clear bit resets it; a set in the clear cycle wins
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            transfer_done_flag <= DONE_FLAG_RST;
        end else if (done_set) begin
            transfer_done_flag <= 1'b1; // [R15] [R9]
        end else if (done_clear) begin
            transfer_done_flag <= 1'b0; // [R10]
        end
    end

    // sender release source, then receiver control
    always_comb begin
        case (sender_ctrl_select)
            TX_SRC_TERM_READY: next_tx_en = term_ready; // [R14]
            TX_SRC_REQ_SEND: next_tx_en = req_send; // [R14]
            TX_SRC_DIR_DRIVE: next_tx_en = dir_drive; // [R13]
            TX_SRC_ALWAYS: next_tx_en = 1'b1;
            default: next_tx_en = 1'b0;
        endcase
        case (receiver_ctrl_select)
            RX_SRC_INHIBIT_BIT: next_rx_en = !rx_inhibit; // [R1] [R2] [R3]
            RX_SRC_RECIPROCAL: next_rx_en = !next_tx_en; // [R1] [R5] [R6]
            default: next_rx_en = 1'b0;
        endcase
    end

    // line side; a blocked receiver presents idle mark so the uart sees no start bit
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_enable_out <= 1'b0;
            rx_enable_out <= 1'b1;
            uart_rxd_out <= 1'b1;
        end else begin
            tx_enable_out <= next_tx_en;
            rx_enable_out <= next_rx_en;
            uart_rxd_out <= next_rx_en ? rx_line_sync : 1'b1; // [R3]
        end
    end

    // host read of offset 7: answer one cycle after the strobe; other offsets belong to the uart
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            io_rd_data_out <= RD_DATA_RST;
            io_rd_valid_out <= 1'b0;
        end else begin
            io_rd_valid_out <= io_rd_in && (io_addr_in == OFFS_DIR_DMA);
            if (io_rd_in && (io_addr_in == OFFS_DIR_DMA)) begin
                io_rd_data_out <= RD_DATA_RST;
                io_rd_data_out[RD_DIR_DRIVE_BIT] <= dir_drive; // [R13]
                io_rd_data_out[RD_DONE_FLAG_BIT] <= transfer_done_flag; // [R8] [R9]
            end
        end
    end

    // dma pacing: request while the uart holds data and the block is not done; drop on acknowledge
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dma_req_out <= 4'h0;
            done_irq_out <= 1'b0;
        end else begin
            dma_req_out <= (uart_rx_ready_in && !transfer_done_flag && !dma_ack_sel) ? CH_MASK : 4'h0; // [R12]
            done_irq_out <= transfer_done_flag;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    AST_DONE_SETS: assert property ( // [R15]
        done_set |=> transfer_done_flag ##1 done_irq_out
    ) else $error("terminal count did not set the done latch");

    AST_DONE_CLEARS: assert property ( // [R10]
        (done_clear && !done_set) |=> !transfer_done_flag
    ) else $error("clear bit did not reset the done latch");

    AST_DONE_HOLDS: assert property ( // [R10]
        (transfer_done_flag && !done_clear) |=> transfer_done_flag
    ) else $error("done latch dropped without a clear");

    AST_READ_DONE: assert property ( // [R8]
        (io_rd_in && io_addr_in == OFFS_DIR_DMA) |=>
            io_rd_valid_out && (io_rd_data_out[RD_DONE_FLAG_BIT] == $past(transfer_done_flag))
            && (io_rd_data_out[RD_DIR_DRIVE_BIT] == $past(dir_drive))
    ) else $error("offset 7 read returned wrong status");

    AST_INHIBIT_MODE: assert property ( // [R3]
        (receiver_ctrl_select == RX_SRC_INHIBIT_BIT) |=> (rx_enable_out == !$past(rx_inhibit))
    ) else $error("receiver does not follow the inhibit bit");

    AST_RECIPROCAL: assert property ( // [R5]
        (receiver_ctrl_select == RX_SRC_RECIPROCAL) |=> (rx_enable_out != tx_enable_out)
    ) else $error("receiver and sender not reciprocal");

    AST_DIR_RELEASE: assert property ( // [R13]
        (sender_ctrl_select == TX_SRC_DIR_DRIVE) |=> (tx_enable_out == $past(dir_drive))
    ) else $error("sender does not follow direction bit");

    AST_MODEM_RELEASE: assert property ( // [R14]
        (sender_ctrl_select == TX_SRC_REQ_SEND) |=> (tx_enable_out == $past(req_send))
    ) else $error("sender does not follow request-to-send bit");

    AST_BLOCKED_IDLE: assert property ( // [R3]
        !rx_enable_out |-> uart_rxd_out
    ) else $error("blocked receiver passed line data");

    // a request on a channel the card is not strapped to would pace the wrong transfer
    AST_DRQ_CHANNEL: assert property ( // [R12]
        (dma_req_out & ~CH_MASK) == 4'h0
    ) else $error("dma request on wrong channel");

    AST_DRQ_DONE: assert property ( // [R12]
        transfer_done_flag |=> !dma_req_out[DMA_CHANNEL]
    ) else $error("dma request after done");
endmodule

// *** testbench/dma_host_model.sv ***
module dma_host_model (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [3:0] req_in,
    input wire logic tc_arm_in,
    output logic [3:0] ack_n_out,
    output logic tc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // one acknowledge per request, never held, so a stuck request shows up as repeated acks
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_n_out <= 4'hF;
            tc_out <= 1'b0;
        end else if (req_in[0] && ack_n_out[0]) begin
            ack_n_out <= 4'hE;
            tc_out <= tc_arm_in; // terminal count only rides on an ack
        end else begin
            ack_n_out <= 4'hF;
            tc_out <= 1'b0;
        end
    end
endmodule

// *** testbench/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dir_dma_pkg::*;
    logic clk, rst_n, wr, rd, rx_ready, rsel, line, tc_arm, rval, irq, rxd, rxen, txen, tc;
    logic [2:0] addr;
    logic [7:0] wd, rdat;
    logic [1:0] ssel;
    logic [3:0] req, ack_n;
    logic [31:0] seed;
    int errors, check_count, cycles, dir, inh, dtr, rts, done, i;

    half_duplex_dir_dma_status u_half_duplex_dir_dma_status (.clk_sys_in(clk), .arst_n_in(rst_n),
        .io_addr_in(addr), .io_wr_data_in(wd), .io_wr_in(wr), .io_rd_in(rd), .io_rd_data_out(rdat),
        .io_rd_valid_out(rval), .uart_rx_ready_in(rx_ready), .dma_ack_n_in(ack_n), .dma_tc_in(tc),
        .dma_req_out(req), .done_irq_out(irq), .receiver_ctrl_select_in(rsel),
        .sender_ctrl_select_in(ssel), .rx_line_in(line), .uart_rxd_out(rxd), .rx_enable_out(rxen),
        .tx_enable_out(txen));
    dma_host_model u_dma_host_model (.clk_sys_in(clk), .arst_n_in(rst_n), .req_in(req),
        .tc_arm_in(tc_arm), .ack_n_out(ack_n), .tc_out(tc));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr_io(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wd = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask

    // valid must pulse only for offset 7, exactly one cycle after the strobe
    task automatic rd_io(input logic [2:0] a);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        chk({7'h00, rval}, {7'h00, a == 3'h7});
        if (a == 3'h7) chk(rdat, {6'h00, done[0], dir[0]});
    endtask

    // straps and line pass a synchroniser, so allow it to settle first
    task automatic chk_lines();
        logic t;
        logic r;
        t = (ssel == 2'b00) ? dtr[0] : (ssel == 2'b01) ? rts[0] : (ssel == 2'b10) ? dir[0] : 1'b1;
        r = rsel ? !t : !inh[0];
        repeat (8) @(posedge clk);
        #1 chk({6'h00, txen, rxen}, {6'h00, t, r});
        chk({7'h00, rxd}, {7'h00, r ? line : 1'b1}); // blocked receiver gives mark, open one passes line
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    initial begin
        {rst_n, wr, rd, rx_ready, rsel, line, tc_arm, addr, wd, ssel} = '0;
        seed = 32'hFC430D54;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        rd_io(3'h7);
        chk_lines();
        rd_io(3'h5);
        for (int r = 0; r < 2; r++) begin
            for (int s = 0; s < 4; s++) begin
                rsel = r[0];
                ssel = s[1:0];
                repeat (4) begin
                    seed = lfsr(seed);
                    dtr = seed[0];
                    rts = seed[1];
                    dir = seed[2];
                    inh = seed[3];
                    line = seed[4];
                    wr_io(3'h4, {6'h00, seed[1:0]}); // upper bits written as zero
                    wr_io(3'h7, {5'h00, 1'b0, seed[3:2]});
                    chk_lines();
                    rd_io(3'h7);
                end
            end
        end
        rx_ready = 1'b1;
        // outputs are looked at 1 ns after the edge so the launching edge has settled
        for (i = 0; i < 20 && req[0] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({4'h0, req}, 8'h01);
        tc_arm = 1'b1;
        for (i = 0; i < 30 && irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        tc_arm = 1'b0;
        done = 1;
        chk({7'h00, irq}, 8'h01);
        rd_io(3'h7);
        repeat (4) @(posedge clk);
        #1 chk({4'h0, req}, 8'h00); // no requests once done
        wr_io(3'h7, {5'h00, 1'b0, inh[0], dir[0]}); // current bits kept
        rd_io(3'h7); // clear bit at 0 leaves the flag
        wr_io(3'h7, {5'h00, 1'b1, inh[0], dir[0]});
        done = 0;
        rd_io(3'h7);
        repeat (3) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
        results();
    end
endmodule
